// File: verilog/lsfb_defines.vh
// Word indices, bit positions and sizes of the link status flag bank
`ifndef LSFB_DEFINES_VH
`define LSFB_DEFINES_VH

// Word indices; byte address is four times the index
`define LSFB_LINK_STRIDE     14'h1f4
`define LSFB_IDX_FLAGS       14'h000
`define LSFB_IDX_RUN         14'h00a
`define LSFB_IDX_COMM        14'h014
`define LSFB_IDX_FAULT       14'h01e
`define LSFB_IDX_CFG         14'h028
`define LSFB_IDX_HEALTH      14'h032
`define LSFB_IDX_CTRL        14'h03c
`define LSFB_IDX_IRQ_STAT    14'h03d
`define LSFB_IDX_IRQ_EN      14'h03e
`define LSFB_IDX_IRQ_CLR     14'h03f
`define LSFB_IDX_P2P_SEL     14'h064
`define LSFB_IDX_P2P_DONE    14'h065
`define LSFB_IDX_P2P_CODE    14'h066
`define LSFB_IDX_P2P_OKCNT   14'h067
`define LSFB_IDX_P2P_ERRCNT  14'h068
`define LSFB_GRP_WORDS       14'h008

// Bit positions
`define LSFB_FLAG_OK         0
`define LSFB_FLAG_FAULT      1
`define LSFB_CTRL_EN         0
`define LSFB_CTRL_STOP       1
`define LSFB_IRQ_OK_RISE     0
`define LSFB_IRQ_FAULT_RISE  1
`define LSFB_IRQ_P2P_DONE    2
`define LSFB_IRQ_P2P_FAIL    3
`define LSFB_DONE_OK         0
`define LSFB_DONE_FAULT      1

// Sizes and reset values
`define LSFB_BLK_WORDS       8
`define LSFB_P2P_ENTRIES     512
`define LSFB_RST_WORD        32'h00000000

`endif

// File: verilog/lsfb_blkword.v
// Sixteen blocks of run, comm-ok and fault state with health and masking
`timescale 1ns/1ps
module lsfb_blkword (
	input  wire        clk,       // System clock
	input  wire        reset,     // Async reset, high
	input  wire        upd,       // Update strobe for this word
	input  wire [3:0]  bit_sel,   // Block within the word
	input  wire        run_in,    // Station in run mode
	input  wire        ok_in,     // Block exchanged correctly
	input  wire        err_in,    // Block communication error
	input  wire [15:0] cfg,       // Configured blocks
	output wire [15:0] run,       // Masked run bits
	output wire [15:0] ok,        // Masked comm-ok bits
	output wire [15:0] fault,     // Masked fault bits
	output wire [15:0] health,    // Combined health bits
	output wire        all_good   // Every configured block healthy
);
	reg [15:0] run_q;
	reg [15:0] ok_q;
	reg [15:0] err_q;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			run_q <= 16'h0000;
			ok_q  <= 16'h0000;
			err_q <= 16'h0000;
		end else begin
			// Stale state dropped when a block is unconfigured
			run_q <= run_q & cfg;
			ok_q  <= ok_q & cfg;
			err_q <= err_q & cfg;
			if (upd && cfg[bit_sel]) begin
				run_q[bit_sel] <= run_in;
				ok_q[bit_sel]  <= ok_in;
				err_q[bit_sel] <= err_in;
			end
		end
	end

	assign run      = run_q & cfg;
	assign ok       = ok_q & cfg;
	assign fault    = err_q & cfg;
	assign health   = run & ok & ~fault;
	assign all_good = &(health | ~cfg);
endmodule // lsfb_blkword

// File: verilog/lsfb_flag_bank.v
// Link status flag bank: per-block flags, link health, P2P results, APB slave
`timescale 1ns/1ps
`include "lsfb_defines.vh"

// Behaviour
// - Healthy flag needs all configured blocks good
// - Healthy flag sticky until link stop
// - Trouble flag when healthy and block bad
// - Trouble flag clears when conditions recover
// - Health equals run and ok, not fault
// - Per-block run-mode bit held
// - Per-block comm-ok bit held
// - Per-block fault bit held
// - Per-block configured bit held
// - 128 blocks packed sixteen per word
// - Run array at words ten to seventeen
// - Link area base is 500 times (n-1)
// - P2P normal end sets done-ok bit
// - P2P abnormal end sets done-fault bit
// - Abnormal end stores fault code word
// - Double-word count of normal ends
// - Double-word count of abnormal ends
module lsfb_flag_bank #(
	parameter LINK_NO = 1                  // Link number 1 to 12
) (
	input  wire        CLK,              // 10 MHz clock
	input  wire        RESET,            // Async reset, high
	input  wire        PSEL,             // APB select
	input  wire        PENABLE,          // APB enable
	input  wire        PWRITE,           // APB direction
	input  wire [15:0] PADDR,            // APB byte address
	input  wire [31:0] PWDATA,           // APB write data
	output reg  [31:0] PRDATA,           // APB read data
	output wire        PREADY,           // APB ready
	output wire        PSLVERR,          // APB unmapped access
	input  wire        BLK_UPD,          // Block state update strobe
	input  wire [6:0]  BLK_IDX,          // Block number
	input  wire        BLK_RUN,          // Station in run mode
	input  wire        BLK_OK,           // Block exchanged correctly
	input  wire        BLK_ERR,          // Block error
	input  wire        STN_PARAM_OK,     // Station parameters exchanged ok
	input  wire        P2P_DONE,         // P2P normal end strobe
	input  wire        P2P_FAIL,         // P2P abnormal end strobe
	input  wire [2:0]  P2P_PARAM,        // P2P parameter number minus one
	input  wire [5:0]  P2P_BLOCK,        // P2P block number
	input  wire [15:0] P2P_CODE,         // P2P error code
	output wire        ALL_STATIONS_OK,  // All stations healthy, sticky
	output wire        LINK_FAULT_FLAG,  // Trouble after healthy
	output wire        IRQ               // Level interrupt
);
	localparam integer LINK_BASE_I = 500 * (LINK_NO - 1);
	localparam [13:0]  LINK_BASE   = LINK_BASE_I[13:0];

	reg  [127:0] cfg_all;
	wire [127:0] run_all;
	wire [127:0] ok_all;
	wire [127:0] fault_all;
	wire [127:0] health_all;
	wire [7:0]   good_w;
	reg          link_en;
	reg          all_ok;
	reg          link_fault;
	reg  [3:0]   irq_stat;
	reg  [3:0]   irq_en;
	reg  [8:0]   p2p_sel;
	reg  [1:0]   done_mem   [0:`LSFB_P2P_ENTRIES-1];
	reg  [15:0]  code_mem   [0:`LSFB_P2P_ENTRIES-1];
	reg  [31:0]  okcnt_mem  [0:`LSFB_P2P_ENTRIES-1];
	reg  [31:0]  errcnt_mem [0:`LSFB_P2P_ENTRIES-1];
	reg  [31:0]  rd_data;
	reg          dec_err;
	reg          next_all_ok;
	integer      i;

	function grp_hit;
		input [13:0] r;
		input [13:0] b;
		begin
			grp_hit = (r >= b) && (r < b + `LSFB_GRP_WORDS);
		end
	endfunction

	function [6:0] grp_bit;
		input [13:0] r;
		input [13:0] b;
		reg   [13:0] d;
		begin
			d = r - b;
			grp_bit = {d[2:0], 4'h0};
		end
	endfunction

	wire [13:0] word_idx = PADDR[15:2];
	wire [13:0] rel      = word_idx - LINK_BASE;
	wire        in_link  = (word_idx >= LINK_BASE);
	wire        wr       = PSEL && PENABLE && PWRITE;
	wire        rd_setup = PSEL && !PENABLE && !PWRITE;
	wire        wr_ok    = wr && !dec_err;
	wire        wr_ctrl  = wr_ok && (rel == `LSFB_IDX_CTRL);
	wire        stop_cmd = wr_ctrl && PWDATA[`LSFB_CTRL_STOP];
	wire        done_clr = wr_ok && (rel == `LSFB_IDX_P2P_DONE);
	wire [8:0]  ev_idx   = {P2P_PARAM, P2P_BLOCK};
	wire        blocks_good = &good_w;

	// Eight identical words of sixteen blocks each
	genvar g;
	generate
		for (g = 0; g < `LSFB_BLK_WORDS; g = g + 1) begin : gen_word
			localparam [2:0] GW = g;
			lsfb_blkword u_word (
				.clk      (CLK),
				.reset    (RESET),
				.upd      (BLK_UPD && (BLK_IDX[6:4] == GW)),
				.bit_sel  (BLK_IDX[3:0]),
				.run_in   (BLK_RUN),
				.ok_in    (BLK_OK),
				.err_in   (BLK_ERR),
				.cfg      (cfg_all[g*16 +: 16]),
				.run      (run_all[g*16 +: 16]),
				.ok       (ok_all[g*16 +: 16]),
				.fault    (fault_all[g*16 +: 16]),
				.health   (health_all[g*16 +: 16]),
				.all_good (good_w[g])
			);
		end
	endgenerate

	// Address decode and read mux
	always @* begin
		rd_data = `LSFB_RST_WORD;
		dec_err = 1'b0;
		if (!in_link) begin
			dec_err = 1'b1;
		end else if (rel == `LSFB_IDX_FLAGS) begin
			rd_data[`LSFB_FLAG_OK]    = all_ok;
			rd_data[`LSFB_FLAG_FAULT] = link_fault;
		end else if (grp_hit(rel, `LSFB_IDX_RUN)) begin
			rd_data[15:0] = run_all[grp_bit(rel, `LSFB_IDX_RUN) +: 16];
		end else if (grp_hit(rel, `LSFB_IDX_COMM)) begin
			rd_data[15:0] = ok_all[grp_bit(rel, `LSFB_IDX_COMM) +: 16];
		end else if (grp_hit(rel, `LSFB_IDX_FAULT)) begin
			rd_data[15:0] = fault_all[grp_bit(rel, `LSFB_IDX_FAULT) +: 16];
		end else if (grp_hit(rel, `LSFB_IDX_CFG)) begin
			rd_data[15:0] = cfg_all[grp_bit(rel, `LSFB_IDX_CFG) +: 16];
		end else if (grp_hit(rel, `LSFB_IDX_HEALTH)) begin
			rd_data[15:0] = health_all[grp_bit(rel, `LSFB_IDX_HEALTH) +: 16];
		end else if (rel == `LSFB_IDX_CTRL) begin
			rd_data[`LSFB_CTRL_EN] = link_en;
		end else if (rel == `LSFB_IDX_IRQ_STAT) begin
			rd_data[3:0] = irq_stat;
		end else if (rel == `LSFB_IDX_IRQ_EN) begin
			rd_data[3:0] = irq_en;
		end else if (rel == `LSFB_IDX_IRQ_CLR) begin
			rd_data = `LSFB_RST_WORD;
		end else if (rel == `LSFB_IDX_P2P_SEL) begin
			rd_data[8:0] = p2p_sel;
		end else if (rel == `LSFB_IDX_P2P_DONE) begin
			rd_data[1:0] = done_mem[p2p_sel];
		end else if (rel == `LSFB_IDX_P2P_CODE) begin
			rd_data[15:0] = code_mem[p2p_sel];
		end else if (rel == `LSFB_IDX_P2P_OKCNT) begin
			rd_data = okcnt_mem[p2p_sel];
		end else if (rel == `LSFB_IDX_P2P_ERRCNT) begin
			rd_data = errcnt_mem[p2p_sel];
		end else begin
			dec_err = 1'b1;
		end
	end

	// Zero wait states; read data latched in the setup cycle
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && dec_err;

	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			PRDATA <= `LSFB_RST_WORD;
		end else if (rd_setup) begin
			PRDATA <= rd_data;
		end
	end

	// Software registers
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cfg_all <= 128'h0;
			link_en <= 1'b0;
			irq_en  <= 4'h0;
			p2p_sel <= 9'h000;
		end else if (wr_ok) begin
			if (grp_hit(rel, `LSFB_IDX_CFG)) begin
				cfg_all[grp_bit(rel, `LSFB_IDX_CFG) +: 16] <= PWDATA[15:0];
			end
			if (wr_ctrl) begin
				// Stop wins over enable in the same write
				link_en <= PWDATA[`LSFB_CTRL_EN] && !PWDATA[`LSFB_CTRL_STOP];
			end
			if (rel == `LSFB_IDX_IRQ_EN) begin
				irq_en <= PWDATA[3:0];
			end
			if (rel == `LSFB_IDX_P2P_SEL) begin
				p2p_sel <= PWDATA[8:0];
			end
		end
	end

	// Link health evaluation
	always @* begin
		next_all_ok = all_ok;
		if (stop_cmd) begin
			next_all_ok = 1'b0;
		end else if (blocks_good && STN_PARAM_OK && link_en) begin
			next_all_ok = 1'b1;
		end
	end

	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			all_ok     <= 1'b0;
			link_fault <= 1'b0;
		end else begin
			all_ok     <= next_all_ok;
			// Follows conditions both ways, no latching
			link_fault <= next_all_ok && !blocks_good;
		end
	end

	assign ALL_STATIONS_OK = all_ok;
	assign LINK_FAULT_FLAG = link_fault;

	// P2P results; a new end beats a software clear of the same entry
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			for (i = 0; i < `LSFB_P2P_ENTRIES; i = i + 1) begin
				done_mem[i]   <= 2'b00;
				code_mem[i]   <= 16'h0000;
				okcnt_mem[i]  <= 32'h00000000;
				errcnt_mem[i] <= 32'h00000000;
			end
		end else begin
			if (done_clr) begin
				done_mem[p2p_sel] <= done_mem[p2p_sel] & ~PWDATA[1:0];
			end
			if (P2P_DONE || P2P_FAIL) begin
				done_mem[ev_idx] <= (done_mem[ev_idx]
					& ~((done_clr && p2p_sel == ev_idx) ? PWDATA[1:0] : 2'b00))
					| {P2P_FAIL, P2P_DONE};
			end
			if (P2P_DONE) begin
				okcnt_mem[ev_idx] <= okcnt_mem[ev_idx] + 32'h00000001;
			end
			if (P2P_FAIL) begin
				code_mem[ev_idx]   <= P2P_CODE;
				errcnt_mem[ev_idx] <= errcnt_mem[ev_idx] + 32'h00000001;
			end
		end
	end

	// Interrupt status: events set, clear register clears, set wins
	wire [3:0] irq_ev = {P2P_FAIL, P2P_DONE,
		next_all_ok && !blocks_good && !link_fault,
		next_all_ok && !all_ok};
	wire [3:0] irq_clr = (wr_ok && rel == `LSFB_IDX_IRQ_CLR) ? PWDATA[3:0] : 4'h0;

	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			irq_stat <= 4'h0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
		end
	end

	assign IRQ = |(irq_stat & irq_en);
endmodule // lsfb_flag_bank

// File: verif/lsfb_properties.sv
// Port assertions for the link status flag bank
`timescale 1ns/1ps
`include "lsfb_defines.vh"
module lsfb_properties #(parameter LINK_NO = 1) (
	input wire        CLK,             // Clock
	input wire        RESET,           // Reset
	input wire        PSEL,            // Select
	input wire        PENABLE,         // Enable
	input wire        PWRITE,          // Write
	input wire [15:0] PADDR,           // Address
	input wire [31:0] PWDATA,          // Data
	input wire        PSLVERR,         // Error
	input wire        STN_PARAM_OK,    // Params ok
	input wire        ALL_STATIONS_OK, // Healthy
	input wire        LINK_FAULT_FLAG, // Trouble
	input wire        IRQ              // Interrupt
);
	localparam [13:0] BASE = 500 * (LINK_NO - 1);
	wire        acc = PSEL && PENABLE;
	wire [13:0] idx = PADDR[15:2] - BASE;
	wire        stop = acc && PWRITE && idx == `LSFB_IDX_CTRL && PWDATA[`LSFB_CTRL_STOP];
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// Healthy and trouble settle within three edges of a stop
	sequence cleared;
		##3 !ALL_STATIONS_OK && !LINK_FAULT_FLAG;
	endsequence
	a_err_access: assert property (PSLVERR |-> acc) else $error("error outside access");
	a_below_base: assert property (acc && PADDR[15:2] < BASE |-> PSLVERR)
		else $error("no error below base");
	a_fault_needs_ok: assert property (LINK_FAULT_FLAG |-> ALL_STATIONS_OK || $past(ALL_STATIONS_OK))
		else $error("trouble without healthy");
	a_ok_sticky: assert property ($fell(ALL_STATIONS_OK) |-> $past(stop) || $past(stop, 2))
		else $error("healthy fell without stop");
	a_stop_clears: assert property (stop |-> cleared) else $error("stop ignored");
	a_irq_fall: assert property ($fell(IRQ) |-> $past(acc && PWRITE)) else $error("irq fell");
	a_ok_rise_param: assert property ($rose(ALL_STATIONS_OK) |-> $past(STN_PARAM_OK))
		else $error("healthy without params");
	a_reset_clears: assert property ($past(RESET) |-> !ALL_STATIONS_OK && !LINK_FAULT_FLAG && !IRQ)
		else $error("flags after reset");
endmodule // lsfb_properties

// File: verif/lsfb_link_engine.sv
// Link engine model: block reports and P2P completions
`timescale 1ns/1ps
module lsfb_link_engine (
	input  wire        clk,    // Clock
	output reg         upd,    // Update pulse
	output reg  [6:0]  idx,    // Block
	output reg  [2:0]  st,     // Run, ok, error
	output reg         prm_ok, // Params ok
	output reg         done,   // Normal end
	output reg         fail,   // Abnormal end
	output reg  [2:0]  par,    // Parameter
	output reg  [5:0]  blk,    // P2P block
	output reg  [15:0] code    // Error code
);
	initial
		{upd, idx, st, prm_ok, done, fail, par, blk, code} = 0;
	// Fields invert after each pulse so stale values never look valid
	task report(input int gap, input [6:0] i, input [2:0] s);
		repeat (gap + 1) @(posedge clk);
		{upd, idx, st} <= {1'b1, i, s};
		@(posedge clk);
		{upd, idx, st} <= {1'b0, ~i, ~s};
	endtask
	task finish(input int gap, input f, input [2:0] p, input [5:0] b, input [15:0] c);
		repeat (gap + 1) @(posedge clk);
		{done, fail, par, blk, code} <= {!f, f, p, b, c};
		@(posedge clk);
		{done, fail, par, blk, code} <= {2'b00, ~p, ~b, ~c};
	endtask
endmodule // lsfb_link_engine

// File: verif/test_link_status_flag_bank.sv
// Random and corner bench for the link status flag bank
`timescale 1ns/1ps
`include "lsfb_defines.vh"
module test_link_status_flag_bank;
	localparam [13:0] BASE = 14'd500;
	reg          CLK, RESET, PSEL, PENABLE, PWRITE, e, f;
	reg  [15:0]  PADDR, c;
	reg  [31:0]  PWDATA, lfsr, q;
	reg  [31:0]  xp [4];
	reg  [127:0] cfg, m_run, m_ok, m_flt;
	reg  [8:0]   sel;
	wire [31:0]  PRDATA;
	wire         PREADY, PSLVERR, ALL_STATIONS_OK, LINK_FAULT_FLAG, IRQ, upd, pok, dn, fl;
	wire [6:0]   idx;
	wire [2:0]   st, par;
	wire [5:0]   blk;
	wire [15:0]  code;
	int          num_errors, num_checks, i, nok, nf;
	lsfb_flag_bank #(.LINK_NO(2)) uut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .BLK_UPD(upd), .BLK_IDX(idx), .BLK_RUN(st[2]), .BLK_OK(st[1]),
		.BLK_ERR(st[0]), .STN_PARAM_OK(pok), .P2P_DONE(dn), .P2P_FAIL(fl), .P2P_PARAM(par),
		.P2P_BLOCK(blk), .P2P_CODE(code), .ALL_STATIONS_OK(ALL_STATIONS_OK),
		.LINK_FAULT_FLAG(LINK_FAULT_FLAG), .IRQ(IRQ));
	lsfb_link_engine eng (.clk(CLK), .upd(upd), .idx(idx), .st(st), .prm_ok(pok), .done(dn),
		.fail(fl), .par(par), .blk(blk), .code(code));
	initial begin
		CLK = 0;
		forever #50 CLK = ~CLK;
	end
	function [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		rnd = lfsr;
	endfunction
	function [31:0] exp_word(input int a, input int w);
		reg [127:0] v;
		case (a)
			0: v = m_run;
			1: v = m_ok;
			2: v = m_flt;
			3: v = cfg;
			default: v = m_run & m_ok & ~m_flt;
		endcase
		exp_word = v[w * 16 +: 16];
	endfunction
	task end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string n, input [31:0] x, input [31:0] g);
		num_checks++;
		if (g !== x) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, x, g);
		end
	endtask
	task apb(input w, input [13:0] r, input [31:0] d);
		int n;
		@(posedge CLK);
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, BASE + r, 2'b00, d};
		@(posedge CLK);
		PENABLE <= 1;
		n = 0;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1 && ++n < 20);
		if (PREADY !== 1'b1) begin
			num_errors++;
			end_sim;
		end
		q = PRDATA;
		e = PSLVERR;
		{PSEL, PENABLE} <= 0;
	endtask
	// Gap of 1 to 3 idle cycles: prompt and slow engine
	task rep(input [6:0] b, input [2:0] s);
		eng.report(rnd() % 3, b, s);
		if (cfg[b])
			{m_run[b], m_ok[b], m_flt[b]} = s;
	endtask
	task flags(input string n, input [1:0] x);
		repeat (3) @(posedge CLK);
		chk(n, x, {ALL_STATIONS_OK, LINK_FAULT_FLAG});
	endtask
	// Level follows a register written at the access edge, so look mid-cycle
	task irq_chk(input string n, input x);
		@(negedge CLK);
		chk(n, x, IRQ);
	endtask
	initial begin
		RESET = 1;
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 0;
		{cfg, m_run, m_ok, m_flt, c, nok, nf} = 0;
		lfsr = 90714;
		num_errors = 0;
		num_checks = 0;
		repeat (6) @(posedge CLK);
		RESET <= 0;
		apb(1, `LSFB_IDX_FLAGS, 3);
		apb(0, `LSFB_IDX_FLAGS, 0);
		chk("flags", 0, q);
		chk("ok access", 0, e);
		apb(0, 5, 0);
		chk("hole", 1, e);
		apb(1, -1, 0);
		chk("below", 1, e);
		for (i = 0; i < 4; i++)
			cfg[i * 32 +: 32] = rnd();
		{cfg[127], cfg[16], cfg[0]} = 3'b101;
		for (i = 0; i < 8; i++)
			apb(1, `LSFB_IDX_CFG + i, cfg[i * 16 +: 16]);
		apb(1, `LSFB_IDX_CTRL, 1);
		rep(16, 3'b110);
		for (i = 0; i < 60; i++)
			rep(rnd(), rnd());
		for (i = 0; i < 40; i++) begin
			apb(0, `LSFB_IDX_RUN + 10 * (i / 8) + i % 8, 0);
			chk("array", exp_word(i / 8, i % 8), q);
		end
		for (i = 0; i < 128; i++)
			if (cfg[i])
				rep(i, 3'b110);
		flags("no param", 0);
		eng.prm_ok <= 1;
		flags("healthy", 2);
		rep(127, 3'b111);
		flags("trouble", 3);
		rep(127, 3'b110);
		flags("recover", 2);
		rep(0, 3'b100);
		flags("no comm", 3);
		rep(0, 3'b010);
		flags("no run", 3);
		rep(0, 3'b110);
		flags("recover 2", 2);
		apb(1, `LSFB_IDX_IRQ_EN, 2);
		apb(0, `LSFB_IDX_IRQ_STAT, 0);
		chk("irq stat", 3, q);
		irq_chk("irq on", 1);
		apb(1, `LSFB_IDX_IRQ_CLR, 2);
		irq_chk("irq clr", 0);
		apb(1, `LSFB_IDX_IRQ_EN, 1);
		irq_chk("irq unmask", 1);
		apb(1, `LSFB_IDX_IRQ_CLR, 1);
		irq_chk("irq off", 0);
		apb(0, `LSFB_IDX_IRQ_STAT, 0);
		chk("irq stat clr", 0, q);
		apb(1, `LSFB_IDX_CTRL, 2);
		flags("stopped", 0);
		sel = rnd();
		apb(1, `LSFB_IDX_P2P_SEL, sel);
		for (i = 0; i < 6; i++) begin
			f = i == 0 || (i > 1 && rnd() % 2);
			if (f)
				c = rnd();
			eng.finish(rnd() % 3, f, sel[8:6], sel[5:0], c);
			nf += f;
			nok += !f;
		end
		eng.finish(0, 0, sel[8:6], sel[5:0] + 6'd1, 0);
		xp = '{{nf > 0, nok > 0}, c, nok, nf};
		for (i = 0; i < 4; i++) begin
			apb(0, `LSFB_IDX_P2P_DONE + i, 0);
			chk("p2p", xp[i], q);
		end
		apb(1, `LSFB_IDX_P2P_DONE, 3);
		apb(0, `LSFB_IDX_P2P_DONE, 0);
		chk("p2p clr", 0, q);
		RESET <= 1;
		@(posedge CLK);
		RESET <= 0;
		apb(1, `LSFB_IDX_P2P_SEL, sel);
		apb(0, `LSFB_IDX_P2P_OKCNT, 0);
		chk("cnt reset", 0, q);
		end_sim;
	end
endmodule // test_link_status_flag_bank
bind lsfb_flag_bank lsfb_properties #(.LINK_NO(LINK_NO)) props (.CLK(CLK), .RESET(RESET),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PSLVERR(PSLVERR), .STN_PARAM_OK(STN_PARAM_OK), .ALL_STATIONS_OK(ALL_STATIONS_OK),
	.LINK_FAULT_FLAG(LINK_FAULT_FLAG), .IRQ(IRQ));
